// ===== rtl/rtc_pkg.sv
package rtc_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CAPTURE = 4'h4;
  localparam logic [3:0] OFS_ALARM = 4'h8;
  localparam logic [3:0] OFS_OSC = 4'hc;

  // Control register bit positions
  localparam int BIT_OSC_EN = 7;
  localparam int BIT_MON_EN = 6;
  localparam int BIT_OSC_FAIL = 5;
  localparam int BIT_RUN = 4;
  localparam int BIT_ALARM_EN = 3;
  localparam int BIT_ALARM = 2;
  localparam int BIT_LOAD = 1;
  localparam int BIT_CAPTURE = 0;

  // Oscillator control register bit positions
  localparam int BIT_LFO_SEL = 0;
  localparam int BIT_XTAL_VALID = 4;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MISS_TIMEOUT_NS = 100000;
  localparam int BLANK_TIME_NS = 2000000;
  localparam int MISS_CYCLES_DEF = (MISS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYCLES_DEF = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MISS_W = 14;
  localparam int BLANK_W = 17;

  // Timer step per slow cycle: crystal at bit 0, internal oscillator at bit 1
  localparam logic [31:0] STEP_XTAL = 32'h00000001;
  localparam logic [31:0] STEP_LFO = 32'h00000002;

  typedef struct packed {
    logic osc_en;
    logic mon_en;
    logic osc_fail;
    logic run;
    logic alarm_en;
    logic alarm_flag;
    logic load_req;
    logic cap_req;
  } ctrl_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;

endpackage

// ===== rtl/sync_bank.sv
`timescale 1ns/10ps
module sync_bank
  import rtc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // sync_bank

// ===== rtl/rtc_timer_alarm_monitor.sv
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// R1: Monitor enabled and slow clock stuck over 100 us sets the fail flag.
// R2: Fail flag drives an output usable for interrupt, wake or reset.
// R3: Software disables the monitor before changing oscillator settings.
// R4: Crystal valid follows amplitude detector, forced low 2 ms after power-on.
// R5: Software uses the fail flag, not crystal valid, for failure detection.
// R6: 32-bit timer counts slow cycles while run is one, holds otherwise.
// R7: With auto restart, timer clears one slow cycle after alarm drops.
// R8: Alarm bit write sets auto restart; read returns the alarm flag.
// R9: Software programs compare two counts low, four with internal oscillator.
// R10: Timer loads and snapshots work while the timer keeps running.
// R11: Load bit copies holding value into timer, then hardware clears it.
// R12: Capture bit copies timer into holding register, then hardware clears it.
// R13: Alarm raised only when timer exactly equals the compare value.
// R14: Alarm flag drives an output usable for reset, wake or interrupt.
// R15: Software disables alarm, writes compare, then re-enables the alarm.
// R16: Clearing alarm enable also clears the alarm flag.
// R17: Re-enabling without auto restart next matches after a full wrap.
// R18: Alarm flag lasts at most one slow cycle, then clears itself.
// R19: Free-running mode wraps the timer; software adds to compare.
// R20: Interval mode returns timer to zero after every alarm.
// R21: Internal oscillator selected advances the timer at bit one.
// R22: Fail flag stays set until software clears it.
// R23: Transfers between holding register and timer are coherent words.
// R24: Loss timeout uses the system clock and restarts on every slow edge.
module rtc_timer_alarm_monitor
  import rtc_pkg::*;
#(
  parameter int MISS_CYCLES = MISS_CYCLES_DEF,
  parameter int BLANK_CYCLES = BLANK_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic slow_osc_in,
  input wire logic amp_detect_in,
  output logic osc_power_en,
  output logic lfo_select,
  output logic alarm_event,
  output logic osc_fail_event
);

  ctrl_t ctrl_q;
  bus_state_t bus_q;
  logic [31:0] timer_q;
  logic [31:0] timer_d;
  logic [31:0] capture_q;
  logic [31:0] alarm_q;
  logic autorestart_q;
  logic restart_q;
  logic lfo_sel_q;
  logic xtal_valid_q;
  logic osc_prev_q;
  logic [MISS_W-1:0] miss_cnt_q;
  logic [BLANK_W-1:0] blank_cnt_q;
  logic [1:0] sync_bits;
  logic osc_s;
  logic amp_s;
  logic slow_tick;
  logic osc_edge;
  logic wr_take;
  logic ctrl_wr;
  logic match;
  logic miss_hit;
  logic [31:0] rd_mux;
  logic [31:0] step;

  // Both pins are asynchronous to ref_clk
  sync_bank #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({amp_detect_in, slow_osc_in}),
    .sync_out(sync_bits)
  );

  assign osc_s = sync_bits[0];
  assign amp_s = sync_bits[1];

  // Slow clock edges seen in the system domain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
    end
  end

  assign slow_tick = osc_s & ~osc_prev_q;
  assign osc_edge = osc_s ^ osc_prev_q;

  // Bus: one wait cycle, answer on the second edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_q <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= WORD_RESET;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_mux : WORD_RESET;
          end
        end
        BUS_ANSWER: begin
          bus_q <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_q <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Write lands at the edge where the master sees waitrequest low
  assign wr_take = (bus_q == BUS_ANSWER) && avs_write;
  assign ctrl_wr = wr_take && (avs_address == OFS_CTRL) && avs_byteenable[0];

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = WORD_RESET;
    case (avs_address)
      OFS_CTRL: begin
        rd_mux[7:0] = ctrl_q; // see R8
      end
      OFS_CAPTURE: begin
        rd_mux = capture_q;
      end
      OFS_ALARM: begin
        rd_mux = alarm_q;
      end
      OFS_OSC: begin
        rd_mux[BIT_LFO_SEL] = lfo_sel_q;
        rd_mux[BIT_XTAL_VALID] = xtal_valid_q;
      end
      default: begin
        rd_mux = WORD_RESET;
      end
    endcase
  end

  // Plain control bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q.osc_en <= CTRL_RESET[BIT_OSC_EN];
      ctrl_q.mon_en <= CTRL_RESET[BIT_MON_EN];
      ctrl_q.run <= CTRL_RESET[BIT_RUN];
      ctrl_q.alarm_en <= CTRL_RESET[BIT_ALARM_EN];
      autorestart_q <= CTRL_RESET[BIT_ALARM];
    end else if (ctrl_wr) begin
      ctrl_q.osc_en <= avs_writedata[BIT_OSC_EN];
      ctrl_q.mon_en <= avs_writedata[BIT_MON_EN];
      ctrl_q.run <= avs_writedata[BIT_RUN];
      ctrl_q.alarm_en <= avs_writedata[BIT_ALARM_EN];
      autorestart_q <= avs_writedata[BIT_ALARM]; // see R8
    end
  end

  // Oscillator control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lfo_sel_q <= 1'b0;
    end else if (wr_take && avs_address == OFS_OSC && avs_byteenable[0]) begin
      lfo_sel_q <= avs_writedata[BIT_LFO_SEL];
    end
  end

  // Load and capture requests: software sets, hardware clears a cycle later
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q.load_req <= CTRL_RESET[BIT_LOAD];
      ctrl_q.cap_req <= CTRL_RESET[BIT_CAPTURE];
    end else begin
      // A new request in the clearing cycle wins and runs again
      if (ctrl_wr && avs_writedata[BIT_LOAD]) begin
        ctrl_q.load_req <= 1'b1;
      end else begin
        ctrl_q.load_req <= 1'b0; // see R11
      end
      if (ctrl_wr && avs_writedata[BIT_CAPTURE]) begin
        ctrl_q.cap_req <= 1'b1;
      end else begin
        ctrl_q.cap_req <= 1'b0; // see R12
      end
    end
  end

  // Holding and compare registers, one lane per byte
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          capture_q[8*b +: 8] <= WORD_RESET[8*b +: 8];
        end else if (ctrl_q.cap_req) begin
          // Whole word taken in one edge, so never torn
          capture_q[8*b +: 8] <= timer_q[8*b +: 8]; // see R12, R23
        end else if (wr_take && avs_address == OFS_CAPTURE && avs_byteenable[b]) begin
          capture_q[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          alarm_q[8*b +: 8] <= WORD_RESET[8*b +: 8];
        end else if (wr_take && avs_address == OFS_ALARM && avs_byteenable[b]) begin
          alarm_q[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
      end
    end
  endgenerate

  assign step = lfo_sel_q ? STEP_LFO : STEP_XTAL; // see R21

  // Next timer value; a load beats a slow tick landing in the same cycle
  always_comb begin
    timer_d = timer_q;
    if (ctrl_q.load_req) begin
      timer_d = capture_q; // see R10, R11, R23
    end else if (slow_tick) begin
      if (restart_q) begin
        timer_d = WORD_RESET; // see R7, R20
      end else if (ctrl_q.run) begin
        // Plain 32-bit add wraps through zero
        timer_d = timer_q + step; // see R6, R19
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_q <= WORD_RESET;
    end else begin
      timer_q <= timer_d;
    end
  end

  // Next value compared, so the flag rises on the tick that brings the timer to the match
  assign match = ctrl_q.alarm_en && (timer_d == alarm_q); // see R13, R17

  // Alarm flag: one slow cycle wide, dropped by disabling the alarm
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q.alarm_flag <= CTRL_RESET[BIT_ALARM];
    end else if (!ctrl_q.alarm_en) begin
      ctrl_q.alarm_flag <= 1'b0; // see R16
    end else if (slow_tick) begin
      // A stopped timer would match forever; the flag still drops
      ctrl_q.alarm_flag <= match && !ctrl_q.alarm_flag; // see R18
    end
  end

  // Restart armed on the tick that drops the alarm, used on the next
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      restart_q <= 1'b0;
    end else if (slow_tick) begin
      restart_q <= autorestart_q && ctrl_q.alarm_flag; // see R7
    end
  end

  // Loss timeout counted on ref_clk, cleared on either slow edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      miss_cnt_q <= '0;
    end else if (!ctrl_q.mon_en || osc_edge) begin
      miss_cnt_q <= '0; // see R24
    end else if (miss_cnt_q != MISS_W'(MISS_CYCLES)) begin
      miss_cnt_q <= miss_cnt_q + 1'b1;
    end
  end

  assign miss_hit = ctrl_q.mon_en && !osc_edge && (miss_cnt_q == MISS_W'(MISS_CYCLES));

  // Sticky fail flag; hardware set wins over a software clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q.osc_fail <= CTRL_RESET[BIT_OSC_FAIL];
    end else if (miss_hit) begin
      ctrl_q.osc_fail <= 1'b1; // see R1
    end else if (ctrl_wr && !avs_writedata[BIT_OSC_FAIL]) begin
      ctrl_q.osc_fail <= 1'b0; // see R22
    end
  end

  // Blanking after oscillator power-on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blank_cnt_q <= '0;
    end else if (!ctrl_q.osc_en) begin
      blank_cnt_q <= '0;
    end else if (blank_cnt_q != BLANK_W'(BLANK_CYCLES)) begin
      blank_cnt_q <= blank_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xtal_valid_q <= 1'b0;
    end else begin
      xtal_valid_q <= ctrl_q.osc_en && amp_s
                      && (blank_cnt_q == BLANK_W'(BLANK_CYCLES)); // see R4
    end
  end

  // Outputs to interrupt, wake and reset logic
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarm_event <= 1'b0;
      osc_fail_event <= 1'b0;
    end else begin
      alarm_event <= ctrl_q.alarm_flag; // see R14
      osc_fail_event <= ctrl_q.osc_fail; // see R2
    end
  end

  // Pin-side copies of the oscillator controls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_power_en <= 1'b0;
    end else begin
      osc_power_en <= ctrl_q.osc_en;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lfo_select <= 1'b0;
    end else begin
      lfo_select <= lfo_sel_q;
    end
  end

endmodule // rtc_timer_alarm_monitor

// ===== tb/rtc_checker.sv
`timescale 1ns/10ps
module rtc_checker
  import rtc_pkg::*;
#(
  parameter int MISS_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic slow_osc_in,
  input wire logic osc_power_en,
  input wire logic alarm_event,
  input wire logic osc_fail_event
);
  logic slow_q;
  logic [15:0] stuck_q;
  logic [3:0] since_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Saturating, so a long stall never wraps below the limit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slow_q <= 1'b0;
      stuck_q <= '0;
      since_q <= '0;
    end else begin
      slow_q <= slow_osc_in;
      if (slow_osc_in != slow_q) stuck_q <= '0;
      else if (stuck_q != 16'hffff) stuck_q <= stuck_q + 16'h1;
      if (slow_osc_in && !slow_q) since_q <= '0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
    end
  end
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_take; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_take: assert property (p_take) else $error("request not answered");
  property p_fail_hold;
    osc_fail_event && !avs_write && !$past(avs_write) |=> osc_fail_event;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail flag dropped");
  property p_fail_stuck; $rose(osc_fail_event) |-> stuck_q >= MISS_CYCLES; endproperty
  a_fail_stuck: assert property (p_fail_stuck) else $error("fail too early");
  property p_alarm_short; $rose(alarm_event) |-> ##[1:13] !alarm_event; endproperty
  a_alarm_short: assert property (p_alarm_short) else $error("alarm too long");
  property p_alarm_off;
    avs_write && !avs_waitrequest && avs_address == OFS_CTRL && avs_byteenable[0]
      && !avs_writedata[BIT_ALARM_EN] |-> ##2 !alarm_event;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm not cleared");
  property p_alarm_tick; $rose(alarm_event) |-> since_q inside {[2:8]}; endproperty
  a_alarm_tick: assert property (p_alarm_tick) else $error("alarm off tick");
  property p_power; $changed(osc_power_en) |-> $past(avs_write, 2); endproperty
  a_power: assert property (p_power) else $error("power change unasked");
endmodule // rtc_checker

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import rtc_pkg::*;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, slow_osc_in, amp_detect_in;
  logic osc_power_en, lfo_select, alarm_event, osc_fail_event, alarm_q;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [7:0] cv;
  int mismatches, compares, n_alarm;
  rtc_timer_alarm_monitor #(.MISS_CYCLES(20), .BLANK_CYCLES(16)) dut (.ref_clk, .rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .slow_osc_in, .amp_detect_in, .osc_power_en, .lfo_select,
    .alarm_event, .osc_fail_event);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    alarm_q <= alarm_event;
    if (alarm_event === 1'b1 && alarm_q === 1'b0) n_alarm++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One edge idle after release, so no strobe is driven twice in a step
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("unexpected waitrequest expected 0 seen 1");
    end
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, rv);
  endtask
  task ctl(input logic [7:0] v);
    cv = v;
    xfer(1'b1, OFS_CTRL, {24'h0, v}, 4'hf);
  endtask
  // Slow clock stands still between bursts; the tail lets the last tick land
  task ticks(input int n);
    repeat (n) begin
      cyc(6);
      slow_osc_in <= 1'b1;
      cyc(6);
      slow_osc_in <= 1'b0;
    end
    cyc(6);
  endtask
  task automatic snap(input logic [31:0] e);
    xfer(1'b1, OFS_CTRL, {24'h0, cv | 8'h01}, 4'hf);
    rd(OFS_CAPTURE, e, "snapshot");
  endtask
  task automatic load(input logic [31:0] v);
    xfer(1'b1, OFS_CAPTURE, v, 4'hf);
    xfer(1'b1, OFS_CTRL, {24'h0, cv | 8'h02}, 4'hf);
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(20000);
    mismatches++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    slow_osc_in = 1'b0;
    amp_detect_in = 1'b1;
    cv = 8'h00;
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    rd(OFS_CTRL, 32'h0, "ctrl");
    rd(OFS_ALARM, 32'h0, "alarm");
    rd(4'h2, 32'h0, "unmapped");
    xfer(1'b1, OFS_CTRL, 32'hff, 4'he);
    rd(OFS_CTRL, 32'h0, "ctrl lane");
    ctl(8'h80);
    rd(OFS_OSC, 32'h0, "valid blank");
    chk("power", 32'h1, {31'h0, osc_power_en});
    cyc(20);
    rd(OFS_OSC, 32'h10, "valid");
    amp_detect_in <= 1'b0;
    cyc(4);
    rd(OFS_OSC, 32'h0, "valid drop");
    $display("done reset and crystal");
    load(32'h12345678);
    snap(32'h12345678);
    rd(OFS_CTRL, 32'h80, "req clear");
    ticks(3);
    snap(32'h12345678);
    ctl(8'h90);
    ticks(5);
    snap(32'h1234567d);
    xfer(1'b1, OFS_OSC, 32'h1, 4'hf);
    cyc(1);
    chk("lfo", 32'h1, {31'h0, lfo_select});
    ticks(3);
    snap(32'h12345683);
    xfer(1'b1, OFS_OSC, 32'h0, 4'hf);
    load(32'hfffffffe);
    ticks(3);
    snap(32'h00000001);
    $display("done timer");
    xfer(1'b1, OFS_ALARM, 32'h3, 4'hf);
    load(32'h0);
    ctl(8'h98);
    n_alarm = 0;
    ticks(12);
    chk("alarms", 32'd1, 32'(n_alarm));
    ctl(8'h90);
    xfer(1'b1, OFS_ALARM, 32'h5, 4'hf);
    load(32'h0);
    ctl(8'h9c);
    n_alarm = 0;
    ticks(16);
    chk("alarms", 32'd2, 32'(n_alarm));
    snap(32'h2);
    rd(OFS_CTRL, 32'h98, "flag read");
    ctl(8'h90);
    $display("done alarm");
    ctl(8'hd0);
    ticks(4);
    chk("fail", 32'h0, {31'h0, osc_fail_event});
    cyc(30);
    chk("fail", 32'h1, {31'h0, osc_fail_event});
    rd(OFS_CTRL, 32'hf0, "fail bit");
    ctl(8'hb0);
    rd(OFS_CTRL, 32'hb0, "fail sticky");
    ctl(8'h90);
    cyc(2);
    chk("fail", 32'h0, {31'h0, osc_fail_event});
    $display("done monitor");
    final_report;
  end
endmodule // tb_top
bind rtc_timer_alarm_monitor rtc_checker #(.MISS_CYCLES(MISS_CYCLES)) mon_chk (.ref_clk, .rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .slow_osc_in, .osc_power_en, .alarm_event, .osc_fail_event);
